/* File: hdl/ddc_pkg.sv */
package ddc_pkg;
    localparam int NCH = 4;
    localparam int DW = 24;
    localparam int FIRST_FIR_STAGE_TAPS = 32;
    localparam int SECOND_FIR_STAGE_TAPS = 64;
    localparam int FIFO_DEPTH = 4;
    localparam logic [7:0] AGC_GAIN_RST = 8'h80;
    localparam logic [7:0] AGC_TARGET = 8'h40;
    localparam logic [7:0] AGC_GAIN_MAX = 8'hf0;
    localparam logic [15:0] NCO_PH_RST = 16'h0000;
    // Quarter-symmetric sine magnitude, 8 points per half cycle
    localparam logic [7:0] SIN_LUT [8] = '{8'h00, 8'h31, 8'h5a, 8'h75,
                                           8'h7f, 8'h75, 8'h5a, 8'h31};
    typedef enum logic [1:0] {
        FMT_24,
        FMT_16IQ,
        FMT_16MUX,
        FMT_8PACK
    } ddc_fmt_t;
    typedef enum logic {
        FS_IDLE,
        FS_SLOT1
    } ddc_fst_t;
endpackage

/* File: hdl/ddc_top.sv */
`timescale 1ns/10ps
// How it works
// - Test enable feeds a constant to the mixer, giving scaled NCO tones.
// - Order per channel: NCO/mixer, CIC, first FIR, second FIR, resampler.
// - Four identical channels share one copied configuration, except NCO step and test enable, which are per channel.
// - CIC decimation factor is programmable, e.g. ten.
// - First FIR is 32 taps and decimates by two.
// - Second FIR is 64 taps with no decimation.
// - Enabled interpolating half-band doubles the sample rate.
// - Enabled resampler converts rate by a fractional ratio.
// - 24-bit mode: I high word upper, low byte lower, Q next slot.
// - 16-bit I upper and Q lower together in one slot.
// - 16-bit I then Q multiplexed on the upper bus over two slots.
// - Packed 8-bit I and Q share the upper bus in one slot.
// - Lower bus may become two serial outputs per channel.
// - Serial bits per sample stay within the integer decimation ratio.
// - Zero gain slew holds the gain, disabling the AGC.
module ddc_fifo #(
    parameter int W = 48,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    assign o_ready = cnt_q != FULL;
    assign o_valid = cnt_q != '0;
    assign o_data = mem[rp_q];
    always_comb begin
        push = i_valid && o_ready;
        pop = o_valid && i_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem[wp_q] <= i_data;
            end
        end
    end
endmodule

module ddc_chan (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic signed [15:0] i_din,
    input wire logic i_test_en,
    input wire logic signed [15:0] i_test_value,
    input wire logic [15:0] i_nco_step,
    input wire logic [7:0] i_cic_dec,
    input wire logic i_hb_en,
    input wire logic i_rs_en,
    input wire logic [15:0] i_rs_step,
    input wire logic [3:0] i_agc_slew,
    output logic signed [23:0] o_i,
    output logic signed [23:0] o_q,
    output logic o_valid
);
    logic [15:0] ph_q, ph_d;
    logic signed [15:0] x;
    logic signed [23:0] mix [2];
    logic signed [31:0] cic_acc_q [2], cic_acc_d [2];
    logic [7:0] cic_cnt_q, cic_cnt_d, mag;
    logic signed [23:0] cic_q [2], cic_d [2], f1_q [2], f1_d [2];
    logic signed [23:0] f2_q [2], f2_d [2], hb_q [2], hb_d [2];
    logic signed [23:0] hb_prev_q [2], hb_prev_d [2];
    logic signed [23:0] rs_hold_q [2], rs_hold_d [2], rs_q [2], rs_d [2];
    logic signed [23:0] out_q [2], out_d [2];
    logic signed [23:0] f1_mem [2][ddc_pkg::FIRST_FIR_STAGE_TAPS];
    logic signed [23:0] f2_mem [2][ddc_pkg::SECOND_FIR_STAGE_TAPS];
    logic signed [28:0] f1_sum_q [2], f1_sum_d [2];
    logic signed [29:0] f2_sum_q [2], f2_sum_d [2];
    logic signed [24:0] hb_sum [2];
    logic signed [32:0] prod [2];
    logic [4:0] f1_wp_q, f1_wp_d;
    logic [5:0] f2_wp_q, f2_wp_d;
    logic [16:0] rs_acc_q, rs_acc_d;
    logic [7:0] gain_q, gain_d;
    logic cic_v_q, cic_v_d, f1_ph_q, f1_ph_d, f1_v_q, f1_v_d;
    logic f2_v_q, f2_v_d, hb_v_q, hb_v_d, hb_pend_q, hb_pend_d;
    logic rs_v_q, rs_v_d, out_v_q, out_v_d;

    function automatic logic signed [7:0] nco_lut(input logic [3:0] idx);
        logic [7:0] m;
        m = ddc_pkg::SIN_LUT[idx[2:0]];
        return idx[3] ? -$signed(m) : $signed(m);
    endfunction

    assign o_i = out_q[0];
    assign o_q = out_q[1];
    assign o_valid = out_v_q;
    // Sample bus is on this clock; read as two's complement
    assign x = i_test_en ? i_test_value : i_din;
    assign mix[0] = x * nco_lut(ph_q[15:12] + 4'h4);
    assign mix[1] = x * nco_lut(ph_q[15:12]);

    always_comb begin
        ph_d = ph_q + i_nco_step;
        cic_cnt_d = cic_cnt_q + 8'h01;
        cic_v_d = 1'b0;
        f1_wp_d = f1_wp_q;
        f2_wp_d = f2_wp_q;
        f1_ph_d = f1_ph_q;
        f1_v_d = 1'b0;
        f2_v_d = 1'b0;
        hb_v_d = 1'b0;
        hb_pend_d = 1'b0;
        rs_v_d = 1'b0;
        out_v_d = 1'b0;
        rs_acc_d = {1'b0, rs_acc_q[15:0]} + {1'b0, i_rs_step};
        gain_d = gain_q;
        mag = 8'h00;
        for (int k = 0; k < 2; k++) begin
            // Integrate and dump; zero factor acts as one
            cic_acc_d[k] = cic_acc_q[k] + 32'(mix[k]);
            cic_d[k] = cic_q[k];
            if (cic_cnt_d >= i_cic_dec) begin
                cic_d[k] = cic_acc_d[k][31:8];
                cic_acc_d[k] = '0;
            end
            // Running sums stand in for the loaded tap sets
            f1_sum_d[k] = f1_sum_q[k];
            f1_d[k] = f1_q[k];
            if (cic_v_q) begin
                f1_sum_d[k] = f1_sum_q[k] + 29'(cic_q[k])
                    - 29'(f1_mem[k][f1_wp_q]);
                f1_d[k] = f1_sum_d[k][28:5];
            end
            f2_sum_d[k] = f2_sum_q[k];
            f2_d[k] = f2_q[k];
            if (f1_v_q) begin
                f2_sum_d[k] = f2_sum_q[k] + 30'(f1_q[k])
                    - 30'(f2_mem[k][f2_wp_q]);
                f2_d[k] = f2_sum_d[k][29:6];
            end
            // Midpoint first, then the sample itself
            hb_sum[k] = {hb_prev_q[k][23], hb_prev_q[k]}
                + {f2_q[k][23], f2_q[k]};
            hb_prev_d[k] = hb_prev_q[k];
            hb_d[k] = hb_q[k];
            if (hb_pend_q) begin
                hb_d[k] = hb_prev_q[k];
            end else if (f2_v_q) begin
                hb_prev_d[k] = f2_q[k];
                hb_d[k] = i_hb_en ? hb_sum[k][24:1] : f2_q[k];
            end
            // Zero-order hold; output rate is step/65536 of the clock
            rs_hold_d[k] = hb_v_q ? hb_q[k] : rs_hold_q[k];
            rs_d[k] = rs_q[k];
            if (!i_rs_en && hb_v_q) begin
                rs_d[k] = hb_q[k];
            end else if (i_rs_en && rs_acc_d[16]) begin
                rs_d[k] = rs_hold_q[k];
            end
            // Unity gain is 0x80; large gains wrap rather than clip
            prod[k] = rs_q[k] * $signed({1'b0, gain_q});
            out_d[k] = rs_v_q ? prod[k][30:7] : out_q[k];
        end
        if (cic_cnt_d >= i_cic_dec) begin
            cic_cnt_d = 8'h00;
            cic_v_d = 1'b1;
        end
        if (cic_v_q) begin
            f1_wp_d = f1_wp_q + 5'h01;
            f1_ph_d = !f1_ph_q;
            f1_v_d = f1_ph_q;
        end
        if (f1_v_q) begin
            f2_wp_d = f2_wp_q + 6'h01;
            f2_v_d = 1'b1;
        end
        if (f2_v_q || hb_pend_q) begin
            hb_v_d = 1'b1;
            hb_pend_d = f2_v_q && i_hb_en;
        end
        if (!i_rs_en) begin
            rs_acc_d = '0;
            rs_v_d = hb_v_q;
        end else begin
            rs_v_d = rs_acc_d[16];
        end
        if (rs_v_q) begin
            out_v_d = 1'b1;
            mag = out_d[0][23] ? ~out_d[0][23:16] : out_d[0][23:16];
            if (i_agc_slew != 4'h0) begin
                if (mag > ddc_pkg::AGC_TARGET && gain_q > 8'(i_agc_slew))
                    gain_d = gain_q - 8'(i_agc_slew);
                else if (mag < ddc_pkg::AGC_TARGET
                         && gain_q < ddc_pkg::AGC_GAIN_MAX)
                    gain_d = gain_q + 8'(i_agc_slew);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ph_q <= ddc_pkg::NCO_PH_RST;
            cic_cnt_q <= '0;
            cic_acc_q <= '{default: '0};
            {cic_v_q, f1_ph_q, f1_v_q, f2_v_q} <= '0;
            {hb_v_q, hb_pend_q, rs_v_q, out_v_q} <= '0;
            cic_q <= '{default: '0};
            f1_q <= '{default: '0};
            f2_q <= '{default: '0};
            f1_sum_q <= '{default: '0};
            f2_sum_q <= '{default: '0};
            f1_mem <= '{default: '0};
            f2_mem <= '{default: '0};
            {f1_wp_q, f2_wp_q, rs_acc_q} <= '0;
            hb_q <= '{default: '0};
            hb_prev_q <= '{default: '0};
            rs_hold_q <= '{default: '0};
            rs_q <= '{default: '0};
            out_q <= '{default: '0};
            gain_q <= ddc_pkg::AGC_GAIN_RST;
        end else begin
            ph_q <= ph_d;
            cic_cnt_q <= cic_cnt_d;
            cic_acc_q <= cic_acc_d;
            {cic_v_q, f1_ph_q, f1_v_q, f2_v_q} <=
                {cic_v_d, f1_ph_d, f1_v_d, f2_v_d};
            {hb_v_q, hb_pend_q, rs_v_q, out_v_q} <=
                {hb_v_d, hb_pend_d, rs_v_d, out_v_d};
            cic_q <= cic_d;
            f1_q <= f1_d;
            f2_q <= f2_d;
            f1_sum_q <= f1_sum_d;
            f2_sum_q <= f2_sum_d;
            {f1_wp_q, f2_wp_q, rs_acc_q} <= {f1_wp_d, f2_wp_d, rs_acc_d};
            hb_q <= hb_d;
            hb_prev_q <= hb_prev_d;
            rs_hold_q <= rs_hold_d;
            rs_q <= rs_d;
            out_q <= out_d;
            gain_q <= gain_d;
            for (int k = 0; k < 2; k++) begin
                if (cic_v_q) f1_mem[k][f1_wp_q] <= cic_q[k];
                if (f1_v_q) f2_mem[k][f2_wp_q] <= f1_q[k];
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    cic_rate_a: assert property ((cic_v_q && i_cic_dec == 8'h0a) |=>
        (!cic_v_q)[*8] ##1 !cic_v_q ##1 cic_v_q)
        else $error("CIC output spacing wrong");
    first_fir_stage_dec_a: assert property ((f1_v_q && i_cic_dec == 8'h0a)
        |-> ##20 f1_v_q) else $error("First FIR rate wrong");
    second_fir_stage_rate_a: assert property (f1_v_q |=> f2_v_q)
        else $error("Second FIR dropped a sample");
    hb_double_a: assert property ((f2_v_q && i_hb_en)
        |=> hb_v_q ##1 (hb_v_q && hb_q[0] == $past(f2_q[0], 2)))
        else $error("Half-band did not double");
    rs_rate_a: assert property ((rs_v_q && i_rs_en
        && i_rs_step == 16'h8000) |=> !rs_v_q ##1 rs_v_q)
        else $error("Resampler ratio wrong");
    agc_hold_a: assert property ((i_agc_slew == 4'h0) |=>
        gain_q == $past(gain_q)) else $error("Gain moved at zero slew");
    hb_cov_c: cover property (f2_v_q && i_hb_en ##2 hb_v_q);
    rs_cov_c: cover property (rs_v_q && i_rs_en);
endmodule

module ddc_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic signed [15:0] i_din,
    input wire logic [3:0] i_test_en,
    input wire logic signed [15:0] i_test_value,
    input wire logic [63:0] i_nco_step,
    input wire logic [7:0] i_cic_dec,
    input wire logic i_hb_en,
    input wire logic i_rs_en,
    input wire logic [15:0] i_rs_step,
    input wire logic [3:0] i_agc_slew,
    input wire logic [1:0] i_out_chan,
    input wire ddc_pkg::ddc_fmt_t i_fmt_mode,
    input wire logic i_lower_serial,
    input wire logic i_rx_ready,
    input wire logic [3:0] i_ser_bits,
    input wire logic i_ser_split,
    output logic [15:0] o_upper_output_bus,
    output logic [15:0] o_lower_output_bus,
    output logic o_slot0,
    output logic o_slot1,
    output logic [3:0] o_serial_out_a,
    output logic [3:0] o_serial_out_b,
    output logic [3:0] o_ser_sync,
    output logic o_overrun
);
    logic signed [23:0] ch_i [ddc_pkg::NCH], ch_q [ddc_pkg::NCH];
    logic [3:0] ch_v;
    logic [47:0] hold_q, hold_d, f_data;
    logic [23:0] f_i, f_q, q_q, q_d;
    logic hold_v_q, hold_v_d, ovr_d, in_ready, f_valid, pop;
    logic [15:0] up_d, lo_d;
    logic slot0_d, slot1_d;
    ddc_pkg::ddc_fst_t fst_q, fst_d;
    ddc_pkg::ddc_fmt_t mode_q, mode_d;

    for (genvar c = 0; c < ddc_pkg::NCH; c++) begin : g_ch
        logic [23:0] sa_q, sa_d, sb_q, sb_d, sp_q, sp_d;
        logic [3:0] sc_q, sc_d, half;
        logic sy_d;
        ddc_chan u_chan (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_din(i_din),
            .i_test_en(i_test_en[c]),
            .i_test_value(i_test_value),
            .i_nco_step(i_nco_step[16*c +: 16]),
            .i_cic_dec(i_cic_dec),
            .i_hb_en(i_hb_en),
            .i_rs_en(i_rs_en),
            .i_rs_step(i_rs_step),
            .i_agc_slew(i_agc_slew),
            .o_i(ch_i[c]),
            .o_q(ch_q[c]),
            .o_valid(ch_v[c])
        );
        // New sample cuts off an unfinished word
        always_comb begin
            half = {1'b0, i_ser_bits[3:1]};
            sa_d = sa_q << 1;
            sb_d = sb_q << 1;
            sp_d = sp_q;
            sc_d = sc_q;
            sy_d = 1'b0;
            if (ch_v[c] && i_lower_serial && i_ser_bits != 4'h0) begin
                sa_d = ch_i[c];
                sb_d = i_ser_split ? 24'h000000 : ch_q[c];
                sp_d = ch_q[c];
                sc_d = i_ser_split ? {half[2:0], 1'b0} : i_ser_bits;
                sy_d = 1'b1;
            end else if (sc_q != 4'h0) begin
                sc_d = sc_q - 4'h1;
                if (sc_q == 4'h1) begin
                    sa_d = '0;
                    sb_d = '0;
                end else if (i_ser_split && sc_q == half + 4'h1) begin
                    sa_d = sp_q;
                end
            end
        end
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                {sa_q, sb_q, sp_q} <= '0;
                sc_q <= '0;
                o_ser_sync[c] <= 1'b0;
            end else begin
                {sa_q, sb_q, sp_q} <= {sa_d, sb_d, sp_d};
                sc_q <= sc_d;
                o_ser_sync[c] <= sy_d;
            end
        end
        assign o_serial_out_a[c] = sa_q[23];
        assign o_serial_out_b[c] = sb_q[23];
    end

    // Hold stage stalls on a full FIFO; a sample arriving while one is held and the FIFO is full is dropped
    always_comb begin
        hold_v_d = hold_v_q && !in_ready;
        hold_d = hold_q;
        ovr_d = o_overrun;
        if (ch_v[i_out_chan]) begin
            if (!hold_v_d) begin
                hold_v_d = 1'b1;
                hold_d = {ch_i[i_out_chan], ch_q[i_out_chan]};
            end else begin
                ovr_d = 1'b1;
            end
        end
    end

    ddc_fifo #(.W(48), .DEPTH(ddc_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(hold_v_q),
        .o_ready(in_ready),
        .i_data(hold_q),
        .o_valid(f_valid),
        .i_ready(pop),
        .o_data(f_data)
    );
    assign f_i = f_data[47:24];
    assign f_q = f_data[23:0];
    assign pop = fst_q == ddc_pkg::FS_IDLE && f_valid && i_rx_ready;

    always_comb begin
        up_d = o_upper_output_bus;
        lo_d = o_lower_output_bus;
        {slot0_d, slot1_d} = 2'b00;
        fst_d = fst_q;
        mode_d = mode_q;
        q_d = q_q;
        unique case (fst_q)
            ddc_pkg::FS_IDLE: begin
                if (pop) begin
                    slot0_d = 1'b1;
                    q_d = f_q;
                    mode_d = i_fmt_mode;
                    up_d = f_i[23:8];
                    lo_d = 16'h0000;
                    unique case (i_fmt_mode)
                        ddc_pkg::FMT_24: begin
                            lo_d = {f_i[7:0], 8'h00};
                            fst_d = ddc_pkg::FS_SLOT1;
                        end
                        ddc_pkg::FMT_16IQ: lo_d = f_q[23:8];
                        ddc_pkg::FMT_16MUX: fst_d = ddc_pkg::FS_SLOT1;
                        ddc_pkg::FMT_8PACK: up_d = {f_i[23:16], f_q[23:16]};
                    endcase
                    if (i_lower_serial) lo_d = 16'h0000;
                end
            end
            ddc_pkg::FS_SLOT1: begin
                slot1_d = 1'b1;
                fst_d = ddc_pkg::FS_IDLE;
                up_d = q_q[23:8];
                lo_d = (mode_q == ddc_pkg::FMT_24 && !i_lower_serial)
                    ? {q_q[7:0], 8'h00} : 16'h0000;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hold_q <= '0;
            hold_v_q <= 1'b0;
            o_overrun <= 1'b0;
            fst_q <= ddc_pkg::FS_IDLE;
            mode_q <= ddc_pkg::FMT_24;
            q_q <= '0;
            o_upper_output_bus <= '0;
            o_lower_output_bus <= '0;
            o_slot0 <= 1'b0;
            o_slot1 <= 1'b0;
        end else begin
            hold_q <= hold_d;
            hold_v_q <= hold_v_d;
            o_overrun <= ovr_d;
            fst_q <= fst_d;
            mode_q <= mode_d;
            q_q <= q_d;
            o_upper_output_bus <= up_d;
            o_lower_output_bus <= lo_d;
            o_slot0 <= slot0_d;
            o_slot1 <= slot1_d;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    slot_pair_a: assert property ((pop && (i_fmt_mode == ddc_pkg::FMT_24
        || i_fmt_mode == ddc_pkg::FMT_16MUX)) |=> o_slot0 ##1 o_slot1)
        else $error("Second slot missing");
    slot_single_a: assert property ((pop
        && i_fmt_mode == ddc_pkg::FMT_16IQ && !i_lower_serial)
        |=> o_slot0 && o_lower_output_bus == $past(f_q[23:8]) ##1 !o_slot1)
        else $error("Single-slot word wrong");
    word24_a: assert property ((pop && i_fmt_mode == ddc_pkg::FMT_24
        && !i_lower_serial) |=> o_lower_output_bus == {$past(f_i[7:0]), 8'h00}
        ##1 o_upper_output_bus == $past(f_q[23:8], 2))
        else $error("24-bit layout wrong");
    pack_a: assert property ((pop && i_fmt_mode == ddc_pkg::FMT_8PACK)
        |=> o_upper_output_bus == {$past(f_i[23:16]), $past(f_q[23:16])})
        else $error("Packed layout wrong");
    ovr_a: assert property ((hold_v_q && !in_ready && ch_v[i_out_chan])
        |=> o_overrun) else $error("Overrun not flagged");
    word24_c: cover property (pop && i_fmt_mode == ddc_pkg::FMT_24);
    ser_c: cover property (o_ser_sync[0] && i_ser_split);
    full_c: cover property (hold_v_q && !in_ready);
endmodule

/* File: tb/ddc_rx_model.sv */
`timescale 1ns/10ps
module ddc_rx_model (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_stall,
    input wire logic i_slot0,
    input wire logic i_slot1,
    input wire logic [15:0] i_up,
    input wire logic [15:0] i_lo,
    output logic o_rx_ready,
    output int o_n0,
    output int o_n1,
    output logic [15:0] o_up0,
    output logic [15:0] o_lo0,
    output logic [15:0] o_up1
);
    // Plain level; stalls come only when the bench asks
    assign o_rx_ready = !i_stall;
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            o_n0 <= 0;
            o_n1 <= 0;
        end else begin
            if (i_slot0) begin
                o_n0 <= o_n0 + 1;
                o_up0 <= i_up;
                o_lo0 <= i_lo;
            end
            if (i_slot1) begin
                o_n1 <= o_n1 + 1;
                o_up1 <= i_up;
            end
        end
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic signed [15:0] din = 16'h0000;
    logic [3:0] ten = 4'h0;
    logic signed [15:0] tv = 16'h0000;
    logic [7:0] cic = 8'h02;
    logic hb = 1'b0;
    logic rs = 1'b0;
    logic [15:0] rss = 16'h0000;
    logic [1:0] och = 2'h0;
    ddc_pkg::ddc_fmt_t fmt = ddc_pkg::FMT_16IQ;
    logic ser = 1'b0;
    logic [3:0] bits = 4'h0;
    logic split = 1'b0;
    logic clr = 1'b0;
    logic stall = 1'b0;
    logic rdy, s0, s1, ovr;
    logic [15:0] up, lo, up0, lo0, up1;
    logic [3:0] sa, sb, sync;
    int n0, n1;
    int errors = 0;
    int total_checks = 0;
    ddc_top i_ddc_top (.i_clk(clk), .i_rst(rst), .i_din(din),
        .i_test_en(ten), .i_test_value(tv), .i_nco_step(64'h0),
        .i_cic_dec(cic), .i_hb_en(hb), .i_rs_en(rs), .i_rs_step(rss),
        .i_agc_slew(4'h0), .i_out_chan(och), .i_fmt_mode(fmt),
        .i_lower_serial(ser), .i_rx_ready(rdy), .i_ser_bits(bits),
        .i_ser_split(split), .o_upper_output_bus(up),
        .o_lower_output_bus(lo), .o_slot0(s0), .o_slot1(s1),
        .o_serial_out_a(sa), .o_serial_out_b(sb), .o_ser_sync(sync),
        .o_overrun(ovr));
    ddc_rx_model i_ddc_rx_model (.i_clk(clk), .i_clr(clr),
        .i_stall(stall), .i_slot0(s0), .i_slot1(s1), .i_up(up),
        .i_lo(lo), .o_rx_ready(rdy), .o_n0(n0), .o_n1(n1),
        .o_up0(up0), .o_lo0(lo0), .o_up1(up1));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Reset between scenarios, as config is only sampled as static
    task automatic rst_run(input int settle);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (settle) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic t_chan;
        for (int c = 0; c < 5; c++) begin
            @(posedge clk);
            och <= 2'(c % 4);
            ten <= (c < 4) ? 4'(1 << c) : 4'h0;
            tv <= c[0] ? 16'h8001 : 16'h7fff;
            din <= (c < 4) ? 16'h0000 : 16'h8001;
            rst_run(600);
            repeat (20) @(posedge clk);
            @(negedge clk);
            chk("chan_q", 24'h0, 24'(lo0));
            chk("chan_sign", 24'(c[0] || c == 4), 24'(up0[15]));
            chk("chan_nz", 24'h1, 24'(up0 != 16'h0000));
        end
    endtask
    task automatic t_fmt;
        logic [23:0] q;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            och <= 2'h0;
            ten <= 4'h1;
            tv <= 16'h8001;
            fmt <= ddc_pkg::ddc_fmt_t'(m);
            rst_run(600);
            repeat (20) @(posedge clk);
            @(negedge clk);
            q = (m == 0) ? {up1, lo0[7:0]} : (m == 1) ? 24'(lo0) :
                (m == 2) ? {up1[7:0], lo0} : 24'(up0[7:0]);
            chk("fmt_q", 24'h0, q);
            chk("fmt_sign", 24'h1, 24'(up0[15]));
            chk("fmt_slot1", 24'(m == 0 || m == 2), 24'(n1 > 0));
        end
    endtask
    task automatic t_rate;
        int tab [4][5] = '{'{10, 0, 0, 19, 21}, '{5, 0, 0, 39, 41},
                           '{10, 1, 0, 39, 41}, '{10, 1, 1, 12, 13}};
        fmt <= ddc_pkg::FMT_16IQ;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            cic <= 8'(tab[k][0]);
            hb <= tab[k][1][0];
            rs <= tab[k][2][0];
            rss <= 16'h0800;
            rst_run(200);
            repeat (400) @(posedge clk);
            @(negedge clk);
            chk("rate", 24'h1, 24'(n0 >= tab[k][3] && n0 <= tab[k][4]));
        end
    endtask
    task automatic t_ser;
        int n, nb, g;
        logic [15:0] lob;
        for (int sp = 0; sp < 2; sp++) begin
            @(posedge clk);
            hb <= 1'b0;
            rs <= 1'b0;
            cic <= 8'h04;
            ser <= 1'b1;
            bits <= 4'h4;
            split <= sp[0];
            rst_run(600);
            g = 0;
            nb = 0;
            lob = 16'h0000;
            while (sync[0] !== 1'b1 && g < 100) begin
                @(negedge clk);
                g++;
            end
            for (int k = 0; k < 3; k++) begin
                n = 0;
                g = 0;
                do begin
                    n += sa[0];
                    nb += sb[0];
                    lob |= lo;
                    @(negedge clk);
                    g++;
                end while (sync[0] !== 1'b1 && g < 50);
                chk("ser_a_bits", sp ? 24'h2 : 24'h4, 24'(n));
            end
            chk("ser_b_q", 24'h0, 24'(nb));
            chk("ser_lower", 24'h0, 24'(lob));
        end
    endtask
    task automatic t_ovr;
        @(posedge clk);
        ser <= 1'b0;
        cic <= 8'h02;
        chk("ovr_idle", 24'h0, 24'(ovr));
        stall <= 1'b1;
        rst_run(300);
        @(negedge clk);
        chk("ovr_set", 24'h1, 24'(ovr));
        chk("ovr_held", 24'h0, 24'(n0));
        @(posedge clk);
        stall <= 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("drain", 24'h1, 24'(n0 >= 5 && n0 <= 12));
    endtask
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("rst_out", 24'h0, {up, s0, s1, ovr, sync, sa});
        rst <= 1'b0;
        t_chan();
        t_fmt();
        t_rate();
        t_ser();
        t_ovr();
        report_and_stop();
    end
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule
